//--- core/sas_top.sv
module sas_top (
  input wire logic sys_clk_i,       // 100 MHz system clock
  input wire logic rst_i,           // Synchronous reset, active high
  input wire logic [7:0] addr_i,    // Register byte address
  input wire logic wr_i,            // Write strobe, one cycle
  input wire logic [7:0] wdata_i,   // Write data
  input wire logic comp_i,          // Comparator: input above trial level
  output logic [7:0] rdata_o,       // Read data, one cycle after address
  output logic [1:0] chan_sel_o,    // Analog input mux select
  output logic [9:0] dac_code_o,    // Trial code to the resistor ladder
  output logic busy_o               // Conversion in progress
);
  sas_div_if div_bus ();

  logic comp_meta_ff;
  logic comp_sync_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic busy_ff;
  logic nxt_busy;
  logic [1:0] chan_ff;
  logic [1:0] nxt_chan;
  logic [1:0] clk_sel_ff;
  logic [1:0] nxt_clk_sel;
  logic [9:0] sar_ff;
  logic [9:0] nxt_sar;
  logic [9:0] result_ff;
  logic [9:0] nxt_result;
  logic [5:0] tick_cnt_ff;
  logic [5:0] nxt_tick_cnt;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic start_req;

  assign div_bus.sel = clk_sel_ff;
  assign div_bus.run = busy_ff;

  sas_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .dv(div_bus)
  );

  // Comparator comes from the analog side, so it is synchronised first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else begin
      comp_meta_ff <= comp_i;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  // A start while busy is ignored so only one conversion ever runs
  assign start_req = wr_i && (addr_i == sas_pkg::ADDR_CTRL) &&
                     wdata_i[sas_pkg::CTRL_START_BIT] && !busy_ff;

  always_comb begin
    logic [5:0] step;
    logic [3:0] bit_idx;
    step = 6'h00;
    bit_idx = 4'h0;
    nxt_ctrl = ctrl_ff;
    nxt_busy = busy_ff;
    nxt_chan = chan_ff;
    nxt_clk_sel = clk_sel_ff;
    nxt_sar = sar_ff;
    nxt_result = result_ff;
    nxt_tick_cnt = tick_cnt_ff;
    if (wr_i && addr_i == sas_pkg::ADDR_CTRL) begin
      // Channel and clock fields writable at any time; done is hardware owned
      nxt_ctrl[sas_pkg::CTRL_CHAN_LSB +: 2] = wdata_i[sas_pkg::CTRL_CHAN_LSB +: 2];
      nxt_ctrl[sas_pkg::CTRL_CLK_LSB +: 2] = wdata_i[sas_pkg::CTRL_CLK_LSB +: 2];
    end
    if (start_req) begin
      nxt_ctrl[sas_pkg::CTRL_START_BIT] = 1'b1;
      nxt_ctrl[sas_pkg::CTRL_DONE_BIT] = 1'b0;
      nxt_busy = 1'b1;
      nxt_chan = wdata_i[sas_pkg::CTRL_CHAN_LSB +: 2];
      nxt_clk_sel = wdata_i[sas_pkg::CTRL_CLK_LSB +: 2];
      nxt_sar = sas_pkg::SAR_INIT;
      nxt_tick_cnt = 6'h00;
    end else if (busy_ff && div_bus.tick) begin
      nxt_tick_cnt = tick_cnt_ff + 6'h01;
      if (tick_cnt_ff >= 6'(sas_pkg::SETUP_TICKS)) begin
        step = tick_cnt_ff - 6'(sas_pkg::SETUP_TICKS);
        bit_idx = 4'(sas_pkg::RES_BITS - 1) - 4'(step[5:2]);
        // Decide on the last of the four ticks given to each bit
        if (step[1:0] == 2'(sas_pkg::TICKS_PER_BIT - 1)) begin
          nxt_sar[bit_idx] = comp_sync_ff;
          if (bit_idx != 4'h0) begin
            nxt_sar[bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      if (tick_cnt_ff == 6'(sas_pkg::CONV_TICKS - 1)) begin
        nxt_result = nxt_sar;
        nxt_ctrl[sas_pkg::CTRL_DONE_BIT] = 1'b1;
        nxt_ctrl[sas_pkg::CTRL_START_BIT] = 1'b0;
        nxt_busy = 1'b0;
      end
    end
    nxt_ctrl[7:6] = 2'h0;
  end

  always_comb begin
    case (addr_i)
      sas_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
      sas_pkg::ADDR_RES_HI: nxt_rdata = result_ff[9:2];
      sas_pkg::ADDR_RES_LO: nxt_rdata = {6'h00, result_ff[1:0]};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= sas_pkg::CTRL_RESET;
      busy_ff <= 1'b0;
      chan_ff <= 2'h0;
      clk_sel_ff <= 2'h0;
      sar_ff <= 10'h000;
      result_ff <= 10'h000;
      tick_cnt_ff <= 6'h00;
      rdata_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      busy_ff <= nxt_busy;
      chan_ff <= nxt_chan;
      clk_sel_ff <= nxt_clk_sel;
      sar_ff <= nxt_sar;
      result_ff <= nxt_result;
      tick_cnt_ff <= nxt_tick_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign chan_sel_o = chan_ff;
  assign dac_code_o = sar_ff;
  assign busy_o = busy_ff;

  // Helper: system cycles spent busy in the current conversion
  logic [10:0] busy_cyc_ff;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !busy_ff) begin
      busy_cyc_ff <= 11'h000;
    end else begin
      busy_cyc_ff <= busy_cyc_ff + 11'h001;
    end
  end

  // Last tick of a conversion; result and done are written on this edge
  logic finish_now;
  assign finish_now = busy_ff && div_bus.tick && tick_cnt_ff == 6'(sas_pkg::CONV_TICKS - 1);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    start_req;
  endsequence

  sequence s_finish;
    finish_now;
  endsequence

  property p_start_load;
    s_start |=> busy_ff && sar_ff == sas_pkg::SAR_INIT && ctrl_ff[sas_pkg::CTRL_START_BIT];
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load mid-scale");

  property p_done_cleared;
    s_start |=> !ctrl_ff[sas_pkg::CTRL_DONE_BIT];
  endproperty
  a_done_cleared: assert property (p_done_cleared) else $error("done not cleared at start");

  property p_finish_store;
    s_finish |=> ctrl_ff[sas_pkg::CTRL_DONE_BIT] && result_ff == $past(nxt_sar) && !busy_ff;
  endproperty
  a_finish_store: assert property (p_finish_store) else $error("result or done wrong at end");

  property p_idle_after;
    $fell(busy_ff) |-> !ctrl_ff[sas_pkg::CTRL_START_BIT] ##1 (!busy_ff || $past(start_req));
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("converter left idle by itself");

  property p_conv_length;
    $fell(busy_ff) |->
      $past(busy_cyc_ff) == 11'(sas_pkg::CONV_TICKS) * 11'(sas_pkg::div_ratio(clk_sel_ff)) + 11'h000;
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_reset_stop;
    disable iff (1'b0) rst_i |=> !busy_ff && !ctrl_ff[sas_pkg::CTRL_START_BIT];
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("reset left converter running");

  property p_read_hi;
    addr_i == sas_pkg::ADDR_RES_HI && !finish_now |=> rdata_o == result_ff[9:2];
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("high result byte wrong");

  property p_read_lo;
    addr_i == sas_pkg::ADDR_RES_LO |=> rdata_o[7:2] == 6'h00;
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("low result byte upper bits set");

  property p_chan_hold;
    busy_ff && !$rose(busy_ff) |-> $stable(chan_ff);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed mid conversion");

  property p_bit_step;
    busy_ff && div_bus.tick && tick_cnt_ff == 6'(sas_pkg::SETUP_TICKS + sas_pkg::TICKS_PER_BIT - 1)
      |=> sar_ff[9] == $past(comp_sync_ff) && sar_ff[8];
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("first bit decision wrong");
endmodule // sas_top

//--- core/sas_pkg.sv
package sas_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'hEF;
  localparam logic [7:0] ADDR_RES_HI = 8'hF0;
  localparam logic [7:0] ADDR_RES_LO = 8'hF1;

  // Control register field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CLK_LSB = 1;
  localparam int CTRL_DONE_BIT = 3;
  localparam int CTRL_CHAN_LSB = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Mid-scale start value, printed as a 12-bit figure; bits 11:2 form the 10-bit register
  localparam logic [11:0] SAR_INIT_RAW = 12'h800;
  localparam logic [9:0] SAR_INIT = SAR_INIT_RAW[11:2];
  localparam int RES_BITS = 10;

  // Conversion timing in conversion-clock ticks
  localparam int SETUP_TICKS = 10;
  localparam int TICKS_PER_BIT = 4;
  localparam int CONV_TICKS = SETUP_TICKS + TICKS_PER_BIT * RES_BITS;

  // Divider ratios per clock select code
  localparam logic [4:0] DIV_SEL0 = 5'h10;
  localparam logic [4:0] DIV_SEL1 = 5'h08;
  localparam logic [4:0] DIV_SEL2 = 5'h04;
  localparam logic [4:0] DIV_SEL3 = 5'h02;

  function automatic logic [4:0] div_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: div_ratio = DIV_SEL0;
      2'h1: div_ratio = DIV_SEL1;
      2'h2: div_ratio = DIV_SEL2;
      default: div_ratio = DIV_SEL3;
    endcase
  endfunction

endpackage

//--- core/sas_div_if.sv
interface sas_div_if;
  logic [1:0] sel;
  logic run;
  logic tick;
  modport master (output sel, output run, input tick);
  modport divider (input sel, input run, output tick);
endinterface

//--- core/sas_clk_div.sv
module sas_clk_div (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i,     // Synchronous reset
  sas_div_if.divider dv       // Select, run and tick
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Counter held at zero while stopped so every conversion starts on a fresh phase
  always_comb begin
    nxt_cnt = 5'h00;
    nxt_tick = 1'b0;
    if (dv.run) begin
      if (cnt_ff == sas_pkg::div_ratio(dv.sel) - 5'h01) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_ff <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign dv.tick = tick_ff;
endmodule // sas_clk_div

//--- tb/sas_comp_model.sv
module sas_comp_model (
  input wire logic sys_clk_i,        // System clock
  input wire logic slow_i,           // Settle late instead of at once
  input wire logic [1:0] chan_sel_i, // Analog mux select
  input wire logic [9:0] dac_code_i, // Trial code on the ladder
  input wire logic [39:0] levels_i,  // Four 10-bit input levels, channel 0 lowest
  output logic comp_o                // High while the input is above the trial level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lag_ff;
  logic above;
  assign above = levels_i[chan_sel_i * 10 +: 10] > dac_code_i;
  always_ff @(posedge sys_clk_i) lag_ff <= {lag_ff[1:0], above};
  // Slow mode still settles well inside the shortest decision spacing of eight cycles
  assign comp_o = slow_i ? lag_ff[2] : above;
endmodule // sas_comp_model

//--- tb/sar_adc_sequencer_test.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module sar_adc_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, rst_i, wr_i, comp_i, busy_o, slow, rd_req, rd_d, busy_d;
  logic [7:0] addr_i, wdata_i, rdata_o, rd_exp;
  logic [1:0] chan_sel_o, c, s;
  logic [9:0] dac_code_o, res;
  logic [39:0] levels;
  logic [7:0] rd_q[$];
  int len_q[$];
  int dv[4] = '{16, 8, 4, 2};
  int miscompares, total_checks, blen, len_exp;
  sas_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .comp_i(comp_i), .rdata_o(rdata_o), .chan_sel_o(chan_sel_o),
    .dac_code_o(dac_code_o), .busy_o(busy_o));
  sas_comp_model partner (.sys_clk_i(sys_clk_i), .slow_i(slow), .chan_sel_i(chan_sel_o),
    .dac_code_i(dac_code_o), .levels_i(levels), .comp_o(comp_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_req <= 1'b1;
    rd_q.push_back(e);
    @(posedge sys_clk_i);
    rd_req <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && busy_o !== 1'b0; n++) @(posedge sys_clk_i);
    if (n == 1000) begin
      miscompares++;
      stop_test();
    end
  endtask
  // Expected code from a bitwise search with the trial bit kept when the input is above it
  function automatic logic [9:0] sar(input logic [9:0] lv);
    logic [9:0] code;
    code = 10'h000;
    for (int b = 9; b >= 0; b--) if (lv > (code | (10'h001 << b))) code |= 10'h001 << b;
    return code;
  endfunction
  always @(posedge sys_clk_i) begin
    rd_d <= rd_req;
    busy_d <= busy_o;
    // Pop once into a holder; the compare macro reads its expected value twice
    if (rd_d) begin
      rd_exp = rd_q.pop_front();
      `CHK(rdata_o, rd_exp)
    end
    if (busy_o === 1'b1 && busy_d !== 1'b1) begin
      `CHK(dac_code_o, 10'h200)
      `CHK(chan_sel_o, c)
    end
    if (busy_o === 1'b1) blen++;
    if (busy_o !== 1'b1 && busy_d === 1'b1) begin
      `CHK(dac_code_o, res)
      `CHK(chan_sel_o, c)
      // A conversion nobody started shows up as an empty queue
      if (len_q.size() == 0) `CHK(blen, 0)
      else begin
        len_exp = len_q.pop_front();
        `CHK(blen, len_exp)
      end
      blen = 0;
    end
  end
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    rd_req = 1'b0;
    slow = 1'b0;
    blen = 0;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(32'h58B8));
    levels = {10'h3FF, 10'($urandom), 10'($urandom), 10'h000};
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(sas_pkg::ADDR_CTRL, 8'h00);
    rd(sas_pkg::ADDR_RES_HI, 8'h00);
    rd(sas_pkg::ADDR_RES_LO, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      c = 2'(3 - i);
      // At this system clock every select gives a conversion shorter than the analog minimum;
      // the model comparator settles at once or, for odd selects, three cycles late, so only the digital sequence is judged here
      s = 2'(i);
      slow <= i[0];
      res = sar(levels[c * 10 +: 10]);
      len_q.push_back(50 * dv[i] + 1);
      wr(sas_pkg::ADDR_CTRL, {2'b00, c, 1'b0, s, 1'b1});
      rd(sas_pkg::ADDR_CTRL, {2'b00, c, 1'b0, s, 1'b1});
      // New channel mid-run must not disturb this conversion; the repeated start is ignored
      wr(sas_pkg::ADDR_CTRL, {2'b00, ~c, 1'b0, s, 1'b1});
      wait_idle();
      rd(sas_pkg::ADDR_CTRL, {2'b00, ~c, 1'b1, s, 1'b0});
      rd(sas_pkg::ADDR_RES_HI, res[9:2]);
      rd(sas_pkg::ADDR_RES_LO, {6'h00, res[1:0]});
      wr(sas_pkg::ADDR_RES_HI, 8'($urandom));
      wr(sas_pkg::ADDR_RES_LO, 8'($urandom));
      rd(sas_pkg::ADDR_RES_HI, res[9:2]);
      rd(sas_pkg::ADDR_RES_LO, {6'h00, res[1:0]});
      repeat (20) @(posedge sys_clk_i);
      $display("test conversion %0d done", i);
    end
    // Reset in mid-conversion must stop the converter; mux and trial code return to zero
    c = 2'h0;
    res = 10'h000;
    len_q.push_back(31);
    wr(sas_pkg::ADDR_CTRL, 8'h03);
    repeat (30) @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(sas_pkg::ADDR_CTRL, 8'h00);
    repeat (20) @(posedge sys_clk_i);
    $display("test reset mid-run done");
    stop_test();
  end
endmodule // sar_adc_sequencer_test
